/* File: core/saf_pkg.sv */
/*
 * Shared constants and types of the stream acquisition framer.
 * Assumes a 40 MHz system clock; holds the scan timing and sample buffer figures and the framing tags, codes and length biases.
 */
package saf_pkg;

	localparam int CLOCK_HZ = 40_000_000;
	localparam int CLOCK_PERIOD_NS = 25;

	localparam int FIFO_DEPTH = 256;
	localparam int FIFO_ADDR_W = 8;
	localparam int COUNT_W = 9;
	localparam int MAX_CHANNELS = 25;

	localparam logic [51:0] BASE_SLOW_HZ = 52'h0_0000_003D_0900;
	localparam logic [51:0] BASE_FAST_HZ = 52'h0_0000_02DC_6C00;
	localparam logic [51:0] CLOCK_HZ_W = 52'h0_0000_0262_5A00;
	localparam logic [51:0] CLOCK_HZ_DIV = 52'h0_0002_625A_0000;

	localparam int SETUP_CLOCK_BIT = 3;
	localparam int SETUP_DIVIDE_BIT = 2;
	localparam int SETUP_RES_LSB = 0;

	localparam logic [7:0] SINGLE_ENDED_CODE = 8'h1F;
	localparam logic [7:0] DIGITAL_FIRST_CODE = 8'hC1;
	localparam logic [7:0] DIGITAL_LAST_CODE = 8'hE0;

	localparam logic [7:0] START_BYTE = 8'hA8;
	localparam logic [7:0] REPLY_TAG = 8'hA9;
	localparam logic [7:0] PACKET_TAG = 8'hF9;
	localparam logic [7:0] PACKET_TYPE = 8'hC0;
	localparam logic [7:0] LENGTH_BIAS = 8'h04;
	localparam logic [5:0] HEADER_BYTES = 6'h0C;
	localparam logic [5:0] TRAILER_BIAS = 6'h0D;

	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_RECOVERING = 8'h3B;
	localparam logic [7:0] ERR_RECOVERED = 8'h3C;
	localparam logic [7:0] ERR_START_REFUSED = 8'h30;

	localparam logic [15:0] DUMMY_SAMPLE = 16'hFFFF;
	localparam logic [15:0] MISSED_MAX = 16'hFFFF;
	localparam logic [7:0] BACKLOG_MAX = 8'hFF;

	typedef enum logic [1:0] {
		SC_IDLE = 2'b00,
		SC_ISSUE = 2'b01,
		SC_WAIT = 2'b10,
		SC_DUMMY = 2'b11
	} saf_scan_type;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_REPLY = 2'b01,
		TX_PACKET = 2'b10
	} saf_tx_type;

endpackage : saf_pkg

/* File: core/saf_sample_buffer.sv */
/*
 * First-in first-out sample buffer of the stream framer.
 * Assumes the writer checks for room before a scan; a push into a full buffer or a pop from an empty one is dropped.
 */
`timescale 1ns/1ps
`default_nettype none

module saf_sample_buffer (
	input wire logic clock,
	input wire logic rst_n,
	saf_sample_if.store bus
);
	import saf_pkg::*;

	typedef struct packed {
		logic [FIFO_ADDR_W-1:0] wr;
		logic [FIFO_ADDR_W-1:0] rd;
		logic [COUNT_W-1:0] count;
	} saf_buf_state_type;

	saf_buf_state_type s;
	saf_buf_state_type next_s;
	logic [15:0] mem [FIFO_DEPTH];
	logic doPush;
	logic doPop;

	// The oldest word is always on the read port, so a packet byte can be taken without waiting.
	assign bus.popData = mem[s.rd];
	assign bus.count = s.count;

	always_comb
	begin
		next_s = s;
		doPush = bus.push && (s.count != COUNT_W'(FIFO_DEPTH));
		doPop = bus.pop && (s.count != '0);
		if (doPush)
		begin
			next_s.wr = s.wr + 1'b1;
		end
		if (doPop)
		begin
			next_s.rd = s.rd + 1'b1; // RULE13
		end
		if (doPush && !doPop)
		begin
			next_s.count = s.count + 1'b1;
		end
		else if (doPop && !doPush)
		begin
			next_s.count = s.count - 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
		if (doPush)
		begin
			mem[s.wr] <= bus.pushData;
		end
	end

endmodule : saf_sample_buffer

`default_nettype wire

/* File: core/saf_sample_if.sv */
/*
 * Sample path between the framer and its sample buffer.
 * Assumes both ends share one clock; the buffer presents its oldest word without a read latency.
 */
`timescale 1ns/1ps
`default_nettype none

interface saf_sample_if;
	import saf_pkg::*;

	logic push;
	logic [15:0] pushData;
	logic pop;
	logic [15:0] popData;
	logic [COUNT_W-1:0] count;

	modport store (
		input push,
		input pushData,
		input pop,
		output popData,
		output count
	);

	modport feed (
		output push,
		output pushData,
		output pop,
		input popData,
		input count
	);

endinterface : saf_sample_if

`default_nettype wire

/* File: core/saf_stream_framer.sv */
/*
 * Stream acquisition engine: scan timing, channel table scanning, auto-recovery and data packet framing.
 * Assumes command bytes, configuration strobes, the converter handshake and the byte sink all run on clock.
 */
// Functional notes
// RULE1 - While streaming, every scan converts the whole channel table in order.
// RULE2 - The host configures channels and scan clock before sending start.
// RULE3 - Channels per scan must be 1 to 25.
// RULE4 - Samples per packet, 1 to 25, sets samples per data packet.
// RULE5 - Setup byte picks 4 or 48 MHz base, divide by 256, resolution.
// RULE6 - Scan interval equals period count divided by base clock frequency.
// RULE7 - Positive code selects flexible, extended, temperature, regulator or digital channels.
// RULE8 - Negative code selects input lines, reference, or 31 for single-ended.
// RULE9 - Host never sends negative code 199; it sends 31 instead.
// RULE10 - Start is 0xA8 0xA8; reply is sum, 0xA9, error, zero.
// RULE11 - Packets carry 0xF9, 4 plus samples, 0xC0, samples from byte 12.
// RULE12 - Byte 10 holds an 8-bit packet count that wraps after 255.
// RULE13 - Samples leave oldest first as 16-bit values.
// RULE14 - Differential samples are signed, single-ended samples unsigned.
// RULE15 - Fill byte reports remaining buffered data, scaled 0 to 255; the code sends the sample count unscaled, held at 255.
// RULE16 - Time mark is empty normally; after recovery bytes 6-7 hold missed count.
// RULE17 - A too full buffer enters auto-recovery and discards new scans.
// RULE18 - During recovery buffered data keeps flowing with error code 59.
// RULE19 - Recovery ends once buffered samples fall below samples per packet.
// RULE20 - First packet after recovery has code 60 and one all-ones dummy scan.
// RULE21 - The dummy scan may sit anywhere and spill into later packets.
// RULE22 - That packet's time mark counts discarded scans including the dummy.
// RULE23 - Reserved setup and configuration bits are ignored.
`timescale 1ns/1ps
`default_nettype none

module saf_stream_framer (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic configLoad,
	input wire logic [4:0] channelsPerScan,
	input wire logic [4:0] samplesInPacket,
	input wire logic [7:0] scanSetup,
	input wire logic [15:0] scanPeriodCount,
	input wire logic tableWrite,
	input wire logic [4:0] tableIndex,
	input wire logic [7:0] positiveInputSelect,
	input wire logic [7:0] negativeInputSelect,
	input wire logic rxValid,
	input wire logic [7:0] rxByte,
	output logic convStart,
	output logic [7:0] convPositive,
	output logic [7:0] convNegative,
	output logic convDigital,
	output logic [1:0] convResolution,
	input wire logic convDone,
	input wire logic [15:0] convResult,
	output logic txValid,
	output logic [7:0] txByte,
	output logic txLast,
	input wire logic txReady,
	output logic streaming,
	output logic autoRecovery
);
	import saf_pkg::*;

	typedef struct packed {
		logic configured;
		logic [4:0] chans;
		logic [4:0] spp;
		logic [7:0] setup;
		logic [15:0] period;
		logic [MAX_CHANNELS-1:0][15:0] scanTable;
		logic streaming;
		logic rxFirst;
		logic replyPending;
		logic [7:0] replyErr;
		logic [51:0] timeAcc;
		logic [51:0] threshold;
		saf_scan_type scanState;
		logic [4:0] scanIdx;
		logic diffSample;
		logic recovering;
		logic [15:0] missed;
		logic markPending;
		logic [15:0] markValue;
		saf_tx_type txState;
		logic [5:0] byteIdx;
		logic [7:0] pktErr;
		logic [15:0] pktMark;
		logic [7:0] seq;
		logic txValid;
		logic [7:0] txByte;
		logic txLast;
		logic convStart;
		logic [7:0] convPos;
		logic [7:0] convNeg;
		logic convDigital;
	} saf_state_type;

	saf_state_type s;
	saf_state_type next_s;
	saf_sample_if sampleBus ();

	logic pushReq;
	logic [15:0] pushWord;
	logic popReq;
	logic scanTick;
	logic loadByte;
	logic [51:0] accSum;
	logic [51:0] baseInc;
	logic [15:0] entry;
	logic [5:0] lastIdx;
	logic [COUNT_W-1:0] level;

	function automatic logic [15:0] sat_inc(input logic [15:0] v);
		sat_inc = (v == MISSED_MAX) ? v : v + 1'b1;
	endfunction : sat_inc

	function automatic logic in_range(input logic [4:0] v);
		in_range = (v != 5'h00) && (v <= 5'(MAX_CHANNELS));
	endfunction : in_range

	saf_sample_buffer sampleStore (
		.clock(clock),
		.rst_n(rst_n),
		.bus(sampleBus.store)
	);

	assign sampleBus.push = pushReq;
	assign sampleBus.pushData = pushWord;
	assign sampleBus.pop = popReq;
	assign level = sampleBus.count;

	always_comb
	begin
		next_s = s;
		pushReq = 1'b0;
		pushWord = 16'h0000;
		popReq = 1'b0;
		scanTick = 1'b0;
		entry = s.scanTable[s.scanIdx];
		lastIdx = TRAILER_BIAS + {s.spp, 1'b0};
		loadByte = !s.txValid || txReady;
		next_s.convStart = 1'b0;

		// Configuration is frozen while streaming so the packet length never changes mid-stream.
		if (configLoad && !s.streaming)
		begin
			next_s.configured = in_range(channelsPerScan) && in_range(samplesInPacket)
				&& (scanPeriodCount != 16'h0000); // RULE3 RULE4 RULE6
			next_s.chans = channelsPerScan;
			next_s.spp = samplesInPacket;
			next_s.setup = {4'h0, scanSetup[3:0]}; // RULE23
			next_s.period = scanPeriodCount;
		end
		if (tableWrite && !s.streaming && (tableIndex < 5'(MAX_CHANNELS)))
		begin
			next_s.scanTable[tableIndex] = {positiveInputSelect, negativeInputSelect};
		end

		// Two consecutive start bytes form the start command; anything else restarts the match.
		if (rxValid)
		begin
			if (rxByte == START_BYTE && s.rxFirst)
			begin
				next_s.rxFirst = 1'b0;
				next_s.replyPending = 1'b1; // RULE10
				if (s.configured && !s.streaming)
				begin
					next_s.replyErr = ERR_NONE; // RULE2
					next_s.streaming = 1'b1;
					next_s.seq = 8'h00;
					next_s.recovering = 1'b0;
					next_s.missed = 16'h0000;
					next_s.markPending = 1'b0;
					next_s.timeAcc = 52'h0_0000_0000_0000;
					next_s.threshold = {36'h0_0000_0000, s.period}
						* (s.setup[SETUP_DIVIDE_BIT] ? CLOCK_HZ_DIV : CLOCK_HZ_W); // RULE5 RULE6
				end
				else
				begin
					next_s.replyErr = ERR_START_REFUSED;
				end
			end
			else
			begin
				next_s.rxFirst = (rxByte == START_BYTE);
			end
		end

		// Exact scan timing: the base frequency is added each system cycle against period times system rate (times 256 when dividing).
		baseInc = s.setup[SETUP_CLOCK_BIT] ? BASE_FAST_HZ : BASE_SLOW_HZ; // RULE5
		accSum = s.timeAcc + baseInc;
		if (s.streaming)
		begin
			if (accSum >= s.threshold)
			begin
				scanTick = 1'b1; // RULE6
				next_s.timeAcc = accSum - s.threshold;
				// Scans faster than the system clock cannot be met; the excess is dropped, not accumulated.
				if (next_s.timeAcc >= s.threshold)
				begin
					next_s.timeAcc = 52'h0_0000_0000_0000;
				end
			end
			else
			begin
				next_s.timeAcc = accSum;
			end
		end

		case (s.scanState)
			SC_IDLE:
			begin
				if (s.streaming && s.recovering && (level < COUNT_W'(s.spp)))
				begin
					next_s.recovering = 1'b0; // RULE19
					next_s.markPending = 1'b1; // RULE20
					next_s.markValue = sat_inc(s.missed); // RULE22
					next_s.scanIdx = 5'h00;
					next_s.scanState = SC_DUMMY;
				end
				else if (s.streaming && scanTick)
				begin
					if (s.recovering)
					begin
						next_s.missed = sat_inc(s.missed); // RULE17
					end
					else if ((level + COUNT_W'(s.chans)) > COUNT_W'(FIFO_DEPTH))
					begin
						next_s.recovering = 1'b1; // RULE17
						next_s.missed = 16'h0001;
					end
					else
					begin
						next_s.scanIdx = 5'h00; // RULE1
						next_s.scanState = SC_ISSUE;
					end
				end
			end
			SC_ISSUE:
			begin
				next_s.convStart = 1'b1;
				next_s.convPos = entry[15:8]; // RULE7
				next_s.convNeg = entry[7:0]; // RULE8
				next_s.convDigital = (entry[15:8] >= DIGITAL_FIRST_CODE) && (entry[15:8] <= DIGITAL_LAST_CODE); // RULE7
				next_s.diffSample = (entry[7:0] != SINGLE_ENDED_CODE); // RULE8 RULE9
				next_s.scanState = SC_WAIT;
			end
			SC_WAIT:
			begin
				if (convDone)
				begin
					pushReq = 1'b1;
					// The converter returns offset binary; flipping the top bit yields two's complement.
					pushWord = s.diffSample ? {~convResult[15], convResult[14:0]} : convResult; // RULE14
					if (s.scanIdx == s.chans - 1'b1)
					begin
						next_s.scanState = SC_IDLE;
					end
					else
					begin
						next_s.scanIdx = s.scanIdx + 1'b1; // RULE1
						next_s.scanState = SC_ISSUE;
					end
				end
			end
			SC_DUMMY:
			begin
				pushReq = 1'b1;
				pushWord = DUMMY_SAMPLE; // RULE20 RULE21
				if (s.scanIdx == s.chans - 1'b1)
				begin
					next_s.scanState = SC_IDLE;
				end
				else
				begin
					next_s.scanIdx = s.scanIdx + 1'b1;
				end
			end
			default:
			begin
				next_s.scanState = SC_IDLE;
			end
		endcase

		if (s.txValid && txReady)
		begin
			next_s.txValid = 1'b0;
			next_s.txLast = 1'b0;
		end

		case (s.txState)
			TX_IDLE:
			begin
				if (loadByte && s.replyPending)
				begin
					next_s.replyPending = 1'b0;
					next_s.txState = TX_REPLY;
					next_s.byteIdx = 6'h01;
					next_s.txValid = 1'b1;
					next_s.txByte = REPLY_TAG + s.replyErr; // RULE10
				end
				else if (loadByte && s.streaming && (level >= COUNT_W'(s.spp)))
				begin
					next_s.txState = TX_PACKET;
					next_s.byteIdx = 6'h01;
					next_s.txValid = 1'b1;
					next_s.txByte = 8'h00;
					next_s.markPending = 1'b0;
					next_s.pktMark = s.markPending ? s.markValue : 16'h0000; // RULE16 RULE22
					if (s.markPending)
					begin
						next_s.pktErr = ERR_RECOVERED; // RULE20
					end
					else if (s.recovering)
					begin
						next_s.pktErr = ERR_RECOVERING; // RULE18
					end
					else
					begin
						next_s.pktErr = ERR_NONE;
					end
				end
			end
			TX_REPLY:
			begin
				if (loadByte)
				begin
					next_s.txValid = 1'b1;
					next_s.byteIdx = s.byteIdx + 1'b1;
					case (s.byteIdx)
						6'h01: next_s.txByte = REPLY_TAG;
						6'h02: next_s.txByte = s.replyErr;
						default: next_s.txByte = 8'h00;
					endcase
					if (s.byteIdx == 6'h03)
					begin
						next_s.txLast = 1'b1; // RULE10
						next_s.txState = TX_IDLE;
					end
				end
			end
			TX_PACKET:
			begin
				if (loadByte)
				begin
					next_s.txValid = 1'b1;
					next_s.byteIdx = s.byteIdx + 1'b1;
					if (s.byteIdx == lastIdx)
					begin
						next_s.txByte = 8'h00;
						next_s.txLast = 1'b1;
						next_s.seq = s.seq + 1'b1; // RULE12
						next_s.txState = TX_IDLE;
					end
					else if (s.byteIdx == lastIdx - 1'b1)
					begin
						// The last pop has already lowered the level, so this is what stays behind.
						next_s.txByte = level[8] ? BACKLOG_MAX : level[7:0]; // RULE15
					end
					else if (s.byteIdx >= HEADER_BYTES)
					begin
						if (!s.byteIdx[0])
						begin
							next_s.txByte = sampleBus.popData[7:0]; // RULE13
						end
						else
						begin
							next_s.txByte = sampleBus.popData[15:8];
							popReq = 1'b1; // RULE13
						end
					end
					else
					begin
						case (s.byteIdx)
							6'h01: next_s.txByte = PACKET_TAG; // RULE11
							6'h02: next_s.txByte = LENGTH_BIAS + {3'h0, s.spp}; // RULE11 RULE4
							6'h03: next_s.txByte = PACKET_TYPE; // RULE11
							6'h06: next_s.txByte = s.pktMark[7:0]; // RULE16
							6'h07: next_s.txByte = s.pktMark[15:8]; // RULE16
							6'h0A: next_s.txByte = s.seq; // RULE12
							6'h0B: next_s.txByte = s.pktErr; // RULE18
							default: next_s.txByte = 8'h00;
						endcase
					end
				end
			end
			default:
			begin
				next_s.txState = TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign convStart = s.convStart;
	assign convPositive = s.convPos;
	assign convNegative = s.convNeg;
	assign convDigital = s.convDigital;
	assign convResolution = s.setup[SETUP_RES_LSB +: 2]; // RULE5
	assign txValid = s.txValid;
	assign txByte = s.txByte;
	assign txLast = s.txLast;
	assign streaming = s.streaming;
	assign autoRecovery = s.recovering;

endmodule : saf_stream_framer

`default_nettype wire

/* File: testbench/saf_host_model.sv */
/*
 * Far side of the framer: the converter and the byte-draining host.
 * Assumes one shared clock; stall and slow come from the bench.
 */
`timescale 1ns/1ps
`default_nettype none

module saf_host_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic convStart,
	input wire logic [7:0] convPositive,
	input wire logic [7:0] convNegative,
	input wire logic slow,
	input wire logic stall,
	output logic convDone,
	output logic [15:0] convResult,
	output logic txReady
);
	import saf_pkg::*;
	logic [15:0] expQ[$];
	logic [15:0] r;
	logic [7:0] cnt;
	logic [7:0] neg;
	logic [3:0] pos;
	logic [2:0] left;

	assign txReady = !stall;

	// Between results the bus flips every cycle, so a stale word is never taken for a sample.
	always @(posedge clock)
	begin
		convDone <= 1'b0;
		convResult <= ~convResult;
		if (!rst_n)
		begin
			convResult <= 16'h0000;
			left <= 3'h0;
			cnt <= 8'h00;
			expQ.delete();
		end
		else if (convStart)
		begin
			pos <= convPositive[3:0];
			neg <= convNegative;
			left <= slow ? 3'h4 : 3'h1;
		end
		else if (left != 3'h0)
		begin
			left <= left - 3'h1;
			if (left == 3'h1)
			begin
				r = {4'h0, pos, cnt};
				convDone <= 1'b1;
				convResult <= r;
				cnt <= cnt + 8'h01;
				expQ.push_back(neg == SINGLE_ENDED_CODE ? r : r ^ 16'h8000);
			end
		end
	end
endmodule : saf_host_model

`default_nettype wire

/* File: testbench/saf_stream_framer_test.sv */
/*
 * Self-checking bench of the stream framer.
 * Assumes the host model and the port checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none

module saf_stream_framer_test;
	import saf_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic configLoad = 1'b0;
	logic [4:0] channelsPerScan = 5'h03;
	logic [4:0] samplesInPacket = 5'h19;
	logic [7:0] scanSetup = 8'h81;
	logic [15:0] scanPeriodCount = 16'h0003;
	logic tableWrite = 1'b0;
	logic [4:0] tableIndex = 5'h00;
	logic [7:0] positiveInputSelect = 8'h00;
	logic [7:0] negativeInputSelect = 8'h00;
	logic rxValid = 1'b0;
	logic [7:0] rxByte = 8'h00;
	logic stall = 1'b0;
	logic slow = 1'b0;
	logic convStart, convDigital, convDone, txValid, txLast, txReady, streaming, autoRecovery;
	logic [7:0] convPositive, convNegative, txByte;
	logic [1:0] convResolution;
	logic [15:0] convResult;
	int n_errors = 0;
	int n_checks = 0;
	int cyc, lastT, recCyc, nPkt, k, dummyLeft, i, inBuf, dumPend;
	logic [7:0] seed = 8'h0C;
	logic [1:0] stallMode = 2'h2;
	logic [7:0] seq, expErr, expBack;
	logic timing, recSeen, recDone, prevRec, open;
	logic [7:0] frame[$];
	logic [7:0] replyQ[$];
	logic [7:0] tabPos[3] = '{8'h05, 8'h09, 8'hC8};
	logic [7:0] tabNeg[3] = '{8'h1F, 8'h03, 8'h1F};
	logic [4:0] badCh[5] = '{5'h00, 5'h1A, 5'h03, 5'h03, 5'h03};
	logic [4:0] badSpp[5] = '{5'h19, 5'h19, 5'h00, 5'h1A, 5'h19};

	saf_stream_framer i_saf_stream_framer (.clock, .rst_n, .configLoad, .channelsPerScan, .samplesInPacket, .scanSetup,
		.scanPeriodCount, .tableWrite, .tableIndex, .positiveInputSelect, .negativeInputSelect, .rxValid, .rxByte,
		.convStart, .convPositive, .convNegative, .convDigital, .convResolution, .convDone, .convResult, .txValid,
		.txByte, .txLast, .txReady, .streaming, .autoRecovery);
	saf_host_model i_saf_host_model (.clock, .rst_n, .convStart, .convPositive, .convNegative, .slow, .stall,
		.convDone, .convResult, .txReady);

	always #12.5 clock = ~clock;

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] want);
		n_checks++;
		if (seen !== want)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, want, seen);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask : tick

	task automatic sendStart(input logic [7:0] err);
		replyQ.push_back(err);
		rxValid = 1'b1;
		rxByte = START_BYTE;
		tick(2);
		rxValid = 1'b0;
		tick(1);
	endtask : sendStart

	task automatic loadConfig(input logic [4:0] ch, input logic [4:0] spp, input logic [15:0] per);
		channelsPerScan = ch;
		samplesInPacket = spp;
		scanPeriodCount = per;
		configLoad = 1'b1;
		tick(1);
		configLoad = 1'b0;
		tick(1);
	endtask : loadConfig

	task automatic writeTable();
		tableWrite = 1'b1;
		for (int j = 0; j < 3; j++)
		begin
			tableIndex = 5'(j);
			positiveInputSelect = tabPos[j];
			negativeInputSelect = tabNeg[j];
			tick(1);
		end
		tableWrite = 1'b0;
	endtask : writeTable

	task automatic checkFrame();
		logic [15:0] s;
		if (frame.size() == 4)
		begin
			chk("reply tag", frame[1], REPLY_TAG);
			chk("reply code", frame[2], replyQ.pop_front());
			chk("reply sum", frame[0], 8'(frame[1] + frame[2]));
			return;
		end
		nPkt++;
		chk("packet size", 16'(frame.size()), 16'h0040);
		chk("packet tag", frame[1], PACKET_TAG);
		chk("length byte", frame[2], 8'h1D);
		chk("backlog", frame[62], expBack);
		chk("sequence", frame[10], seq);
		chk("error code", frame[11], expErr);
		if (expErr == ERR_RECOVERED)
		begin
			s = {frame[7], frame[6]};
			chk("missed scans", 16'(s >= 2 && s <= recCyc / 30 + 2), 16'h0001);
		end
		seq++;
		for (int j = 0; j < 25; j++)
		begin
			s = {frame[13 + 2 * j], frame[12 + 2 * j]};
			if (s === DUMMY_SAMPLE && dummyLeft > 0)
				dummyLeft--;
			else
				chk("sample", s, i_saf_host_model.expQ.pop_front());
		end
	endtask : checkFrame

	always @(posedge clock)
	begin
		#2;
		seed = lfsr(seed);
		stall = stallMode == 2'h1 || (stallMode == 2'h0 && seed[1:0] == 2'h0);
		slow = seed[2];
	end

	always @(posedge clock)
	begin
		cyc++;
		if (!rst_n)
		begin
			frame.delete();
			{open, seq, k, lastT, inBuf, dumPend} = 0;
		end
		else
		begin
			if (convStart)
			begin
				chk("scan order", convPositive, tabPos[k]);
				k = (k + 1) % 3;
				if (convPositive == 8'h05 && timing && lastT != 0 && !scanSetup[3])
					chk("scan spacing", 16'(cyc - lastT), 16'h001E);
				else if (convPositive == 8'h05 && timing && lastT != 0)
					chk("fast spacing", 16'((cyc - lastT) inside {[213:214]}), 16'h0001);
				if (convPositive == 8'h05)
					lastT = cyc;
			end
			if (txValid && !open)
			begin
				open = 1'b1;
				expErr = !recSeen ? 8'h00 : prevRec ? ERR_RECOVERING : recDone ? 8'h00 : ERR_RECOVERED;
				recDone = recDone || expErr == ERR_RECOVERED;
				if (expErr == ERR_RECOVERED)
					dummyLeft = 3;
			end
			// Shadow count of the buffer from the pushes and pops seen here; the backlog byte reads it before this edge.
			if (txValid && txReady && frame.size() == 61)
				expBack = inBuf > 255 ? BACKLOG_MAX : 8'(inBuf);
			if (prevRec && !autoRecovery)
				dumPend = 3;
			inBuf += convDone + (dumPend > 0) - (txValid && txReady && frame.size() % 2 == 0
				&& frame.size() inside {[12:60]} && frame[1] == PACKET_TAG);
			dumPend -= (dumPend > 0);
			if (txValid && txReady)
				frame.push_back(txByte);
			if (txValid && txReady && txLast)
			begin
				checkFrame();
				frame.delete();
				open = 1'b0;
			end
			recSeen = recSeen || autoRecovery;
			recCyc += autoRecovery;
			prevRec = autoRecovery;
		end
	end

	initial
	begin
		{cyc, recCyc, nPkt, dummyLeft, timing, recSeen, recDone, prevRec} = 0;
		tick(16);
		rst_n = 1'b1;
		tick(1);
		sendStart(ERR_START_REFUSED);
		tick(10);
		chk("idle unconfigured", streaming, 1'b0);
		writeTable();
		loadConfig(5'h03, 5'h19, 16'h0003);
		rxValid = 1'b1;
		rxByte = 8'h55;
		tick(1);
		sendStart(ERR_NONE);
		tick(10);
		chk("streaming", streaming, 1'b1);
		stallMode = 2'h0;
		timing = 1'b1;
		tick(50);
		sendStart(ERR_START_REFUSED);
		for (i = 0; i < 80000 && nPkt < 258; i++)
			tick(1);
		timing = 1'b0;
		stallMode = 2'h1;
		for (i = 0; i < 4000 && !autoRecovery; i++)
			tick(1);
		chk("recovery entered", autoRecovery, 1'b1);
		tick(300);
		stallMode = 2'h2;
		for (i = 0; i < 5000 && !(recDone && dummyLeft == 0); i++)
			tick(1);
		chk("recovered", {recDone, autoRecovery}, 2'h2);
		chk("dummy scan", 16'(dummyLeft), 16'h0000);
		rst_n = 1'b0;
		tick(2);
		chk("reset outputs", {streaming, autoRecovery, txValid, convStart}, 4'h0);
		rst_n = 1'b1;
		tick(1);
		for (i = 0; i < 5; i++)
		begin
			loadConfig(badCh[i], badSpp[i], i == 4 ? 16'h0000 : 16'h0003);
			sendStart(ERR_START_REFUSED);
			tick(12);
		end
		chk("replies drained", 16'(replyQ.size()), 16'h0000);
		scanSetup = 8'h0E;
		writeTable();
		loadConfig(5'h03, 5'h19, 16'h0001);
		sendStart(ERR_NONE);
		timing = 1'b1;
		i = nPkt;
		tick(2500);
		chk("fast base packets", 16'(nPkt - i), 16'h0001);
		tally_and_finish();
	end

	initial
	begin
		repeat (95000) @(posedge clock);
		n_errors++;
		tally_and_finish();
	end
endmodule : saf_stream_framer_test

`default_nettype wire

/* File: testbench/saf_stream_properties.sv */
/*
 * Port checks of the stream framer.
 * Assumes configuration ports stay steady while streaming.
 */
`timescale 1ns/1ps
`default_nettype none

module saf_stream_properties (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [4:0] samplesInPacket,
	input wire logic [7:0] scanSetup,
	input wire logic rxValid,
	input wire logic [7:0] rxByte,
	input wire logic convStart,
	input wire logic [7:0] convPositive,
	input wire logic convDigital,
	input wire logic [1:0] convResolution,
	input wire logic txValid,
	input wire logic [7:0] txByte,
	input wire logic txLast,
	input wire logic txReady,
	input wire logic streaming,
	input wire logic autoRecovery
);
	logic [6:0] idx;
	logic isPkt;
	logic haveSeq;
	logic [7:0] lastSeq;
	logic prevRec;
	logic waitFirst;
	logic recAtStart;

	// The error byte is fixed when a frame loads, so recovery is taken from the cycle before it shows.
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			idx <= 7'h00;
			isPkt <= 1'b0;
			haveSeq <= 1'b0;
			lastSeq <= 8'h00;
			prevRec <= 1'b0;
			waitFirst <= 1'b0;
			recAtStart <= 1'b0;
		end
		else
		begin
			prevRec <= autoRecovery;
			waitFirst <= txValid && idx == 7'h00 && !txReady;
			if (txValid && idx == 7'h00 && !waitFirst)
				recAtStart <= prevRec;
			if (txValid && txReady)
				idx <= txLast ? 7'h00 : idx + 7'h01;
			if (txValid && txReady && idx == 7'h01)
				isPkt <= txByte == 8'hF9;
			if (txValid && txReady && isPkt && idx == 7'h0A)
				lastSeq <= txByte;
			haveSeq <= streaming && (haveSeq || (txValid && txReady && isPkt && idx == 7'h0A));
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence startPair;
		rxValid && rxByte == 8'hA8 ##1 rxValid && rxByte == 8'hA8;
	endsequence

	sequence replyTag;
		txValid && idx == 7'h01 && txByte == 8'hA9;
	endsequence

	conv_pulse_a: assert property (convStart |=> !convStart)
		else $error("conversion start longer than one cycle");
	conv_digital_a: assert property (convStart |-> convDigital == (convPositive inside {[8'hC1:8'hE0]}))
		else $error("digital flag does not match code");
	conv_res_a: assert property (convStart && streaming |-> convResolution == scanSetup[1:0])
		else $error("resolution differs from setup");
	tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txByte) && $stable(txLast))
		else $error("byte changed before acceptance");
	pkt_type_a: assert property (txValid && isPkt && idx == 7'h03 |-> txByte == 8'hC0)
		else $error("bad packet type byte");
	pkt_len_a: assert property (txValid && isPkt && idx == 7'h02 |-> txByte == {3'h0, samplesInPacket} + 8'h04)
		else $error("bad length byte");
	pkt_end_a: assert property (txValid && txLast && isPkt |-> idx == 7'h0D + {1'b0, samplesInPacket, 1'b0} && txByte == 8'h00)
		else $error("packet ends at wrong byte");
	reply_end_a: assert property (txValid && txLast && !isPkt |-> idx == 7'h03 && txByte == 8'h00)
		else $error("reply ends at wrong byte");
	seq_step_a: assert property (txValid && isPkt && idx == 7'h0A && haveSeq |-> txByte == lastSeq + 8'h01)
		else $error("sequence count did not step");
	recov_err_a: assert property (txValid && isPkt && idx == 7'h0B && recAtStart |-> txByte == 8'h3B)
		else $error("recovery packet lacks its code");
	recov_quiet_a: assert property (autoRecovery |-> !convStart)
		else $error("scan started during recovery");
	start_reply_a: assert property (startPair |-> ##[1:200] replyTag)
		else $error("no reply to start");
endmodule : saf_stream_properties

bind saf_stream_framer saf_stream_properties i_saf_stream_properties (.clock, .rst_n, .samplesInPacket, .scanSetup,
	.rxValid, .rxByte, .convStart, .convPositive, .convDigital, .convResolution, .txValid, .txByte, .txLast, .txReady,
	.streaming, .autoRecovery);

`default_nettype wire
